// ===== rtl/hbpf_device.sv
`timescale 1ns/1ps
// ============================================================
// Two-entry buffer with valid and ready on both sides
module hbpf_fifo2 #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] mem_ff [2];
   logic [W-1:0] nxt_mem [2];
   logic         wptr_ff, nxt_wptr;
   logic         rptr_ff, nxt_rptr;
   logic [1:0]   count_ff, nxt_count;
   logic         push, pop;

   // Honest full and empty from the fill count
   assign in_ready  = (count_ff != 2'h2);
   assign out_valid = (count_ff != 2'h0);
   assign out_data  = mem_ff[rptr_ff];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointer and count update
   always_comb begin
      nxt_mem   = mem_ff;
      nxt_wptr  = wptr_ff;
      nxt_rptr  = rptr_ff;
      nxt_count = count_ff;
      if (push) begin
         nxt_mem[wptr_ff] = in_data;
         nxt_wptr         = ~wptr_ff;
      end
      if (pop) begin
         nxt_rptr = ~rptr_ff;
      end
      case ({push, pop})
         2'b10:   nxt_count = count_ff + 2'h1;
         2'b01:   nxt_count = count_ff - 2'h1;
         default: nxt_count = count_ff;
      endcase
   end

   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_ff[0] <= '0;
         mem_ff[1] <= '0;
         wptr_ff   <= 1'b0;
         rptr_ff   <= 1'b0;
         count_ff  <= 2'h0;
      end else begin
         mem_ff    <= nxt_mem;
         wptr_ff   <= nxt_wptr;
         rptr_ff   <= nxt_rptr;
         count_ff  <= nxt_count;
      end
   end
endmodule // hbpf_fifo2

// ============================================================
// Device end of the host byte port
module hbpf_device (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // Port configuration
   input  wire logic                       ds_mode,
   input  wire logic                       wide_items,
   // Host pins
   hbpf_if.device                          port,
   // Outbound items from the processor
   input  wire logic                       out_valid,
   output logic                            out_ready,
   input  wire logic [hbpf_pkg::ITEM_W-1:0] out_item,
   // Inbound items to the processor
   output logic                            in_valid,
   input  wire logic                       in_ready,
   output logic [hbpf_pkg::ITEM_W-1:0]     in_item
);
   // Two-flop synchronisers for every pin
   logic [10:0] meta_ff, sync_ff;
   logic        cs_s, rd_s, wr_s;
   logic [7:0]  bus_s;

   // Access tracking and byte pairing
   logic        rd_prev_ff, nxt_rd_prev;
   logic        wr_prev_ff, nxt_wr_prev;
   logic        rsel_ff, nxt_rsel;
   logic        wsel_ff, nxt_wsel;
   logic [7:0]  lo_ff, nxt_lo;
   logic        oe_ff, nxt_oe;
   logic [7:0]  dout_ff, nxt_dout;
   logic        empty_ff, nxt_empty;
   logic        full_ff, nxt_full;
   logic        inst_ff, nxt_inst;
   logic [7:0]  wdat_ff, nxt_wdat;

   // Buffer handshakes
   logic                        ob_valid, ob_pop;
   logic [hbpf_pkg::ITEM_W-1:0] ob_data;
   logic                        ib_ready, ib_push;
   logic [hbpf_pkg::ITEM_W-1:0] ib_data;
   logic                        rd_now, wr_now, rd_start, rd_end, wr_end;

   // ============================================================
   // Pin synchronisers; the first stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= 11'h7ff;
         sync_ff <= 11'h7ff;
      end else begin
         meta_ff <= {port.host_select_n, port.host_read_strobe_n, port.host_write_strobe_n,
                     port.host_bus_byte};
         sync_ff <= meta_ff;
      end
   end

   assign cs_s  = sync_ff[10];
   assign rd_s  = sync_ff[9];
   assign wr_s  = sync_ff[8];
   assign bus_s = sync_ff[7:0];

   // ============================================================
   // Access decode; the AND of both lows gives later-fall start, first-rise end
   // Direction is read from the write pin in data strobe mode, so it must be steady
   assign rd_now   = ds_mode ? (!cs_s & !rd_s & wr_s)
                             : (!cs_s & !rd_s);
   assign wr_now   = ds_mode ? (!cs_s & !rd_s & !wr_s)
                             : (!cs_s & !wr_s);
   assign rd_start = rd_now & !rd_prev_ff;
   assign rd_end   = !rd_now & rd_prev_ff;
   assign wr_end   = !wr_now & wr_prev_ff;

   // ============================================================
   // Next state of the port
   always_comb begin
      nxt_rd_prev = rd_now;
      nxt_wr_prev = wr_now;
      nxt_rsel    = rsel_ff;
      nxt_wsel    = wsel_ff;
      nxt_lo      = lo_ff;
      nxt_oe      = oe_ff;
      nxt_dout    = dout_ff;
      ob_pop      = 1'b0;
      ib_push     = 1'b0;
      ib_data     = {8'h00, bus_s};
      nxt_wdat    = wr_now ? bus_s : wdat_ff; // Byte seen while a write access is decoded
      // Reads: drive from start to end, then advance the outbound item
      if (rd_start) begin
         nxt_oe   = 1'b1;
         nxt_dout = !ob_valid ? 8'h00 : ((wide_items && rsel_ff) ? ob_data[15:8] : ob_data[7:0]);
      end
      if (rd_end) begin
         nxt_oe = 1'b0;
         if (ob_valid) begin
            if (wide_items && !rsel_ff) begin
               nxt_rsel = 1'b1;
            end else begin
               ob_pop   = 1'b1;
               nxt_rsel = 1'b0;
            end
         end
      end
      // Writes: commit the held byte at the end, as the host may drop the bus with the strobe
      // A write into a full buffer is dropped
      if (wr_end && ib_ready) begin
         if (wide_items && !wsel_ff) begin
            nxt_lo   = wdat_ff;
            nxt_wsel = 1'b1;
         end else begin
            ib_push  = 1'b1;
            ib_data  = wide_items ? {wdat_ff, lo_ff} : {8'h00, wdat_ff};
            nxt_wsel = 1'b0;
         end
      end
      // Flags follow the buffers one clock later, two clocks after the strobe end is decoded
      nxt_empty = !ob_valid;
      nxt_full  = !ib_ready;
      nxt_inst  = ds_mode & !ib_ready;
   end

   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_prev_ff <= 1'b0;
         wr_prev_ff <= 1'b0;
         rsel_ff    <= 1'b0;
         wsel_ff    <= 1'b0;
         lo_ff      <= 8'h00;
         oe_ff      <= 1'b0;
         dout_ff    <= 8'h00;
         empty_ff   <= hbpf_pkg::RST_EMPTY;
         full_ff    <= hbpf_pkg::RST_FULL;
         inst_ff    <= hbpf_pkg::RST_FULL;
         wdat_ff    <= 8'h00;
      end else begin
         rd_prev_ff <= nxt_rd_prev;
         wr_prev_ff <= nxt_wr_prev;
         rsel_ff    <= nxt_rsel;
         wsel_ff    <= nxt_wsel;
         lo_ff      <= nxt_lo;
         oe_ff      <= nxt_oe;
         dout_ff    <= nxt_dout;
         empty_ff   <= nxt_empty;
         full_ff    <= nxt_full;
         inst_ff    <= nxt_inst;
         wdat_ff    <= nxt_wdat;
      end
   end

   assign port.dev_bus_oe          = oe_ff;
   assign port.dev_bus_dout        = dout_ff;
   assign port.host_out_empty_flag = empty_ff;
   assign port.inbound_full_flag   = full_ff;
   assign port.host_inbound_status = inst_ff;

   // ============================================================
   // Buffers; a stalled processor fills the inbound one and raises the full flag
   hbpf_fifo2 #(.W(hbpf_pkg::ITEM_W)) u_outbuf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (out_valid),
      .in_ready  (out_ready),
      .in_data   (out_item),
      .out_valid (ob_valid),
      .out_ready (ob_pop),
      .out_data  (ob_data)
   );

   hbpf_fifo2 #(.W(hbpf_pkg::ITEM_W)) u_inbuf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (ib_push),
      .in_ready  (ib_ready),
      .in_data   (ib_data),
      .out_valid (in_valid),
      .out_ready (in_ready),
      .out_data  (in_item)
   );
endmodule // hbpf_device

// ===== rtl/hbpf_host.sv
`timescale 1ns/1ps
// ============================================================
// Host end: turns byte commands into strobed accesses
module hbpf_host (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Convention select
   input  wire logic       ds_mode,
   // Command port
   input  wire logic       cmd_valid,
   input  wire logic       cmd_write,
   input  wire logic [7:0] cmd_data,
   output logic            cmd_ready,
   // Read answers
   output logic            rsp_valid,
   output logic [7:0]      rsp_data,
   // Pins
   hbpf_if.host            port
);
   hbpf_pkg::hbpf_hstate_t state_ff, nxt_state;
   logic [3:0] cnt_ff, nxt_cnt;
   logic       write_ff, nxt_write;
   logic       cs_ff, nxt_cs, rd_ff, nxt_rd, wr_ff, nxt_wr, oe_ff, nxt_oe;
   logic [7:0] dout_ff, nxt_dout;
   logic       ready_ff, nxt_ready, rv_ff, nxt_rv;
   logic [7:0] rdat_ff, nxt_rdat;
   logic [7:0] meta_ff, sync_ff;

   // Bus synchroniser; the first stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= 8'h00;
         sync_ff <= 8'h00;
      end else begin
         meta_ff <= port.host_bus_byte;
         sync_ff <= meta_ff;
      end
   end

   // ============================================================
   // Access sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_write = write_ff;
      nxt_cs    = cs_ff;
      nxt_rd    = rd_ff;
      nxt_wr    = wr_ff;
      nxt_oe    = oe_ff;
      nxt_dout  = dout_ff;
      nxt_ready = 1'b0;
      nxt_rv    = 1'b0;
      nxt_rdat  = rdat_ff;
      case (state_ff)
         hbpf_pkg::HBPF_IDLE: begin
            nxt_ready = 1'b1;
            if (cmd_valid && ready_ff) begin
               nxt_ready = 1'b0;
               nxt_write = cmd_write;
               nxt_cs    = 1'b0;
               nxt_wr    = ds_mode ? !cmd_write : 1'b1;
               nxt_oe    = cmd_write;
               nxt_dout  = cmd_data;
               nxt_cnt   = 4'(hbpf_pkg::DIR_SETUP_CYC - 1);
               nxt_state = hbpf_pkg::HBPF_SETUP;
            end
         end
         hbpf_pkg::HBPF_SETUP: begin
            if (cnt_ff == 4'h0) begin
               nxt_rd    = !(ds_mode || !write_ff);
               nxt_wr    = ds_mode ? wr_ff : !write_ff;
               nxt_cnt   = 4'(hbpf_pkg::STROBE_CYC - 1);
               nxt_state = hbpf_pkg::HBPF_STROBE;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         hbpf_pkg::HBPF_STROBE: begin
            if (cnt_ff == 4'h0) begin
               // Strobe, select and the direction line all rise together
               nxt_rd    = 1'b1;
               nxt_wr    = 1'b1;
               nxt_cs    = 1'b1;
               nxt_oe    = 1'b0;
               nxt_rv    = !write_ff;
               nxt_rdat  = sync_ff;
               nxt_cnt   = 4'(hbpf_pkg::GAP_CYC - 1);
               nxt_state = hbpf_pkg::HBPF_GAP;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         hbpf_pkg::HBPF_GAP: begin
            if (cnt_ff == 4'h0) begin
               nxt_ready = 1'b1;
               nxt_state = hbpf_pkg::HBPF_IDLE;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         default: nxt_state = hbpf_pkg::HBPF_IDLE;
      endcase
   end

   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= hbpf_pkg::HBPF_IDLE;
         cnt_ff   <= 4'h0;
         write_ff <= 1'b0;
         cs_ff    <= 1'b1;
         rd_ff    <= 1'b1;
         wr_ff    <= 1'b1;
         oe_ff    <= 1'b0;
         dout_ff  <= 8'h00;
         ready_ff <= 1'b0;
         rv_ff    <= 1'b0;
         rdat_ff  <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         write_ff <= nxt_write;
         cs_ff    <= nxt_cs;
         rd_ff    <= nxt_rd;
         wr_ff    <= nxt_wr;
         oe_ff    <= nxt_oe;
         dout_ff  <= nxt_dout;
         ready_ff <= nxt_ready;
         rv_ff    <= nxt_rv;
         rdat_ff  <= nxt_rdat;
      end
   end

   assign port.host_select_n       = cs_ff;
   assign port.host_read_strobe_n  = rd_ff;
   assign port.host_write_strobe_n = wr_ff;
   assign port.host_bus_oe         = oe_ff;
   assign port.host_bus_dout       = dout_ff;
   assign cmd_ready                = ready_ff;
   assign rsp_valid                = rv_ff;
   assign rsp_data                 = rdat_ff;
endmodule // hbpf_host

// ===== rtl/hbpf_if.sv
`timescale 1ns/1ps
// ============================================================
// Pins between the host and the device
interface hbpf_if;
   logic       host_select_n;
   logic       host_read_strobe_n;
   logic       host_write_strobe_n;
   logic [7:0] host_bus_dout;
   logic       host_bus_oe;
   logic [7:0] dev_bus_dout;
   logic       dev_bus_oe;
   logic [7:0] host_bus_byte;
   logic       host_out_empty_flag;
   logic       inbound_full_flag;
   logic       host_inbound_status;

   // Resolved bus level; an undriven bus reads as zero
   assign host_bus_byte = dev_bus_oe ? dev_bus_dout : (host_bus_oe ? host_bus_dout : 8'h00);

   modport device (
      input  host_select_n, host_read_strobe_n, host_write_strobe_n, host_bus_byte,
      output dev_bus_dout, dev_bus_oe, host_out_empty_flag, inbound_full_flag, host_inbound_status
   );
   modport host (
      output host_select_n, host_read_strobe_n, host_write_strobe_n, host_bus_dout, host_bus_oe,
      input  host_bus_byte, host_out_empty_flag, inbound_full_flag, host_inbound_status
   );
endinterface

// ===== rtl/hbpf_pkg.sv
// ============================================================
// Shared constants for the host byte port
package hbpf_pkg;
   // Bus and item widths
   localparam int BYTE_W = 8;
   localparam int ITEM_W = 16;
   // Clock period in ps and least strobe width in half clock periods (1.5 clocks)
   localparam int CLK_PS         = 8000;
   localparam int PULSE_MIN_HALF = 3;
   localparam int PULSE_MIN_CYC  = (PULSE_MIN_HALF + 1) / 2;
   // Direction line set up one clock before the data strobe falls
   localparam int DIR_SETUP_CYC  = 1;
   // Two synchroniser stages inside the device
   localparam int SYNC_CYC       = 2;
   // Host strobe low time: covers the device sync and drive latency
   localparam int STROBE_CYC     = PULSE_MIN_CYC + 2 * SYNC_CYC + 2;
   // Idle time between accesses so the device has released the bus
   localparam int GAP_CYC        = 2 * SYNC_CYC + 2;
   // Values after reset
   localparam logic RST_EMPTY    = 1'b1;
   localparam logic RST_FULL     = 1'b0;
   // Host sequencer states, Gray coded along the path
   typedef enum logic [1:0] {
      HBPF_IDLE   = 2'b00,
      HBPF_SETUP  = 2'b01,
      HBPF_STROBE = 2'b11,
      HBPF_GAP    = 2'b10
   } hbpf_hstate_t;
endpackage

// ===== tb/hbpf_asserts.sv
`timescale 1ns/1ps
// ============================================================
// Pin-level checks between the host end and the device end
module hbpf_asserts (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Strobes
   input wire logic       host_select_n,
   input wire logic       host_read_strobe_n,
   input wire logic       host_write_strobe_n,
   // Bus drivers
   input wire logic       host_bus_oe,
   input wire logic [7:0] dev_bus_dout,
   input wire logic       dev_bus_oe,
   // Status flags
   input wire logic       host_out_empty_flag,
   input wire logic       inbound_full_flag,
   input wire logic       host_inbound_status
);
   logic rd_act;
   logic wr_act;

   // Direction line high marks a read in both conventions, so one decode serves
   assign rd_act = !host_select_n && !host_read_strobe_n && host_write_strobe_n;
   assign wr_act = !host_select_n && !host_write_strobe_n;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ============================================================
   // Bus drive follows the read access through the synchroniser
   oe_start_a: assert property ($rose(rd_act) |-> ##[2:4] dev_bus_oe)
      else $error("bus not driven after read start");
   oe_release_a: assert property ($fell(rd_act) |-> ##[2:4] !dev_bus_oe)
      else $error("bus not released after read end");
   oe_cause_a: assert property (dev_bus_oe |-> $past(rd_act, 3))
      else $error("bus driven outside a read");
   bus_contention_a: assert property (!(dev_bus_oe && host_bus_oe))
      else $error("both ends drive the bus");
   read_data_stable_a: assert property (dev_bus_oe && $past(dev_bus_oe) |-> $stable(dev_bus_dout))
      else $error("read data moved while driven");
   write_drive_a: assert property (wr_act |-> host_bus_oe && !dev_bus_oe)
      else $error("write without host data on bus");
   pulse_width_a: assert property ($fell(rd_act || wr_act) |-> $past(rd_act || wr_act, 2))
      else $error("strobe pulse too short");
   dir_steady_a: assert property (!host_select_n && !host_read_strobe_n && $past(!host_select_n && !host_read_strobe_n)
                                  |-> $stable(host_write_strobe_n))
      else $error("direction moved during strobe");

   // ============================================================
   // Flags rise only as the outcome of a finished host access
   empty_rise_a: assert property ($rose(host_out_empty_flag) |->
                                  ($past(rd_act, 3) || $past(rd_act, 4) || $past(rd_act, 5) || $past(rd_act, 6)))
      else $error("empty flag rose without a read");
   full_rise_a: assert property ($rose(inbound_full_flag) |->
                                 ($past(wr_act, 3) || $past(wr_act, 4) || $past(wr_act, 5) || $past(wr_act, 6)))
      else $error("full flag rose without a write");
   status_full_a: assert property (host_inbound_status |-> inbound_full_flag)
      else $error("inbound status without full buffer");
endmodule // hbpf_asserts

// ===== tb/host_byte_port_fifo_bench.sv
`timescale 1ns/1ps
// ============================================================
// Host and device ends joined, driven from both user sides
module host_byte_port_fifo_bench;
   logic                        clk;
   logic                        rst;
   logic                        ds_mode;
   logic                        wide_items;
   logic                        cmd_valid;
   logic                        cmd_write;
   logic [7:0]                  cmd_data;
   logic                        cmd_ready;
   logic                        rsp_valid;
   logic [7:0]                  rsp_data;
   logic                        out_valid;
   logic                        out_ready;
   logic [hbpf_pkg::ITEM_W-1:0] out_item;
   logic                        in_valid;
   logic                        in_ready;
   logic [hbpf_pkg::ITEM_W-1:0] in_item;
   int                          failures;
   int                          n_tests;

   // ============================================================
   // Both ends face each other across one interface
   hbpf_if hbpf_if_i ();
   hbpf_device hbpf_device_i (.clk(clk), .rst(rst), .ds_mode(ds_mode), .wide_items(wide_items), .port(hbpf_if_i),
      .out_valid(out_valid), .out_ready(out_ready), .out_item(out_item),
      .in_valid(in_valid), .in_ready(in_ready), .in_item(in_item));
   hbpf_host hbpf_host_i (.clk(clk), .rst(rst), .ds_mode(ds_mode), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .port(hbpf_if_i));
   hbpf_asserts hbpf_asserts_i (.clk(clk), .rst(rst), .host_select_n(hbpf_if_i.host_select_n),
      .host_read_strobe_n(hbpf_if_i.host_read_strobe_n), .host_write_strobe_n(hbpf_if_i.host_write_strobe_n),
      .host_bus_oe(hbpf_if_i.host_bus_oe), .dev_bus_dout(hbpf_if_i.dev_bus_dout), .dev_bus_oe(hbpf_if_i.dev_bus_oe),
      .host_out_empty_flag(hbpf_if_i.host_out_empty_flag), .inbound_full_flag(hbpf_if_i.inbound_full_flag),
      .host_inbound_status(hbpf_if_i.host_inbound_status));

   // 125 MHz clock
   always #4 clk = ~clk;

   // ============================================================
   // Expected item from the bytes written, low byte first
   function automatic logic [15:0] pack_item(input logic w, input logic [7:0] lo, input logic [7:0] hi);
      return w ? {hi, lo} : {8'h00, lo};
   endfunction

   // Expected byte of a read: low half first, high half second
   function automatic logic [7:0] byte_of(input logic [15:0] item, input int k);
      return k[0] ? item[15:8] : item[7:0];
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (failures == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Inputs change 1 ns after the edge so no race with the design's flops
   task automatic step();
      @(posedge clk);
      #1;
   endtask

   // Bounded wait step; a hang counts as a mismatch
   task automatic tick(inout int n);
      step();
      n++;
      if (n > 300) begin
         failures++;
         report_and_stop();
      end
   endtask

   task automatic do_reset();
      rst = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      step();
   endtask

   // Waiting for cmd_ready also lets the device flags settle
   task automatic host_op(input logic wr, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      q = 8'h00;
      while (cmd_ready !== 1'b1) tick(n);
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_data = d;
      step();
      cmd_valid = 1'b0;
      while (!wr && rsp_valid !== 1'b1) tick(n);
      q = rsp_data;
      while (cmd_ready !== 1'b1) tick(n);
   endtask

   task automatic push_out(input logic [15:0] item);
      int n;
      n = 0;
      out_valid = 1'b1;
      out_item = item;
      while (out_ready !== 1'b1) tick(n);
      step();
      out_valid = 1'b0;
      step();
   endtask

   task automatic pop_in(output logic [15:0] item);
      int n;
      n = 0;
      in_ready = 1'b1;
      while (in_valid !== 1'b1) tick(n);
      item = in_item;
      step();
      in_ready = 1'b0;
      step();
   endtask

   // ============================================================
   // One convention and item width: fill, overflow, drain, then read
   task automatic run_config(input logic ds, input logic w);
      logic [7:0]  b [2];
      logic [7:0]  q;
      logic [15:0] item;
      logic [15:0] exp_q [$];
      int          bpi;
      ds_mode = ds;
      wide_items = w;
      do_reset();
      bpi = w ? 2 : 1;
      check(hbpf_if_i.host_out_empty_flag, hbpf_pkg::RST_EMPTY);
      check(hbpf_if_i.inbound_full_flag, hbpf_pkg::RST_FULL);
      check(hbpf_if_i.dev_bus_oe, 1'b0);
      // Receiver stalls, so the third item meets a full buffer
      for (int i = 0; i < 3; i++) begin
         for (int k = 0; k < bpi; k++) begin
            b[k] = (i == 0) ? 8'hff : 8'($urandom);
            host_op(1'b1, b[k], q);
         end
         if (i < 2) exp_q.push_back(pack_item(w, b[0], b[1]));
         check(hbpf_if_i.inbound_full_flag, i > 0);
         check(hbpf_if_i.host_inbound_status, ds && i > 0);
      end
      foreach (exp_q[j]) begin
         pop_in(item);
         check(item, exp_q[j]);
      end
      repeat (3) step();
      check(in_valid, 1'b0);
      check(hbpf_if_i.inbound_full_flag, 1'b0);
      // Outbound side: fill until refused, then read it out bytewise
      exp_q.delete();
      for (int i = 0; i < 2; i++) begin
         item = 16'($urandom);
         exp_q.push_back(item);
         push_out(item);
      end
      check(out_ready, 1'b0);
      repeat (3) step();
      check(hbpf_if_i.host_out_empty_flag, 1'b0);
      foreach (exp_q[j]) begin
         for (int k = 0; k < bpi; k++) begin
            host_op(1'b0, 8'($urandom), q);
            check(q, byte_of(exp_q[j], k));
            check(hbpf_if_i.host_out_empty_flag, j == 1 && k == bpi - 1);
         end
      end
      // Read of an empty buffer gives zero and leaves it empty
      host_op(1'b0, 8'h00, q);
      check(q, 8'h00);
      check(hbpf_if_i.host_out_empty_flag, 1'b1);
   endtask

   // ============================================================
   // Every convention with both item widths, reset between them
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ds_mode = 1'b0;
      wide_items = 1'b0;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_data = 8'h00;
      out_valid = 1'b0;
      out_item = 16'h0000;
      in_ready = 1'b0;
      failures = 0;
      n_tests = 0;
      void'($urandom(32'h5dd2e20a));
      for (int c = 0; c < 4; c++) run_config(c[0], c[1]);
      report_and_stop();
   end
endmodule // host_byte_port_fifo_bench
